/* wsq_pkg.sv */
// constants, types and field layouts for the waveform sequencer
// Summary of operation
// - one stored point read per sample tick
// - normal rate limits 100 mS/s to 300 MS/s
// - normal format: length must divide by four
// - legacy format: 100 MS/s cap, length by two
// - clock source internal by default, else external inputs
// - external source stops internal generator, paces points
// - link holds number, segment, loops, advance, sync
// - no gap samples between consecutive links
// - loops 1 to 1048576, segment repeats that often
// - sync per-link bit pulse or sequence span level
// - ten tables; choosing one does not enable sequencing
// - single link continuous gives endless segment repeat
// - single link triggered advance acts as burst
// - after last link: wrap, stop holding, or finish gate
// - delete one link or clear whole table
// - auto advance plays all links, then wraps in continuous run or while the gate is open
// - triggered advance only in triggered run mode
// - triggered advance holds level, trigger starts next link
// - stepped advance repeats segment until trigger, loops ignored
// - mixed advance: flag 0 auto, flag 1 waits trigger
// - segment numbers span 1 to 16384
package wsq_pkg;
  // table geometry
  localparam int N_TABLES = 10;
  localparam int N_LINKS = 16;
  localparam int TAB_W = 4;
  localparam int LINK_W = 4;
  localparam int LEN_W = 5;
  // field widths
  localparam int SEG_W = 15;
  localparam int LOOP_W = 21;
  localparam int PT_W = 24;
  localparam int DIV_W = 16;
  localparam int RATE_W = 40;
  // field limits
  localparam logic [SEG_W-1:0] SEG_MIN = 15'h0001;
  localparam logic [SEG_W-1:0] SEG_MAX = 15'h4000;
  localparam logic [LOOP_W-1:0] LOOP_MIN = 21'h0_0001;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 21'h10_0000;
  // sample rate limits, in units of mS/s
  localparam logic [RATE_W-1:0] RATE_MIN = 40'h00_0000_0064;
  localparam logic [RATE_W-1:0] RATE_MAX = 40'h45_d964_b800;
  localparam logic [RATE_W-1:0] RATE_MAX_LEGACY = 40'h17_4876_e800;
  // length granularity masks
  localparam logic [PT_W-1:0] LEN_MASK_NORMAL = 24'h00_0003;
  localparam logic [PT_W-1:0] LEN_MASK_LEGACY = 24'h00_0001;
  // fifo depth
  localparam int FIFO_DEPTH = 16;
  // sample clock source codes
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_ECL = 2'h2;
  // run mode codes
  localparam logic [1:0] RUN_CONT = 2'h0;
  localparam logic [1:0] RUN_TRIG = 2'h1;
  localparam logic [1:0] RUN_GATE = 2'h2;
  // advance mode codes
  localparam logic [1:0] ADV_AUTO = 2'h0;
  localparam logic [1:0] ADV_TRIG = 2'h1;
  localparam logic [1:0] ADV_STEP = 2'h2;
  localparam logic [1:0] ADV_MIX = 2'h3;

  // one sequence table entry; the link number is its index
  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic [LOOP_W-1:0] loops;
    logic adv;
    logic sync;
  } wsq_link_type;

  // one stream word: which point of which segment to play
  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic [PT_W-1:0] point;
    logic sync;
  } wsq_word_type;

  // sticky error flags
  typedef struct packed {
    logic rate;
    logic len;
    logic conflict;
    logic cmd;
  } wsq_err_type;
endpackage

/* wsq_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
module wsq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage
  logic [AW-1:0] wp_reg;  // write index
  logic [AW-1:0] rp_reg;  // read index
  logic [AW:0] cnt_reg;  // fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  // pointers and level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // data store
  always_ff @(posedge clk) begin
    if (push) mem_reg[wp_reg] <= in_data;
  end
endmodule

/* wsq_sample_clock.sv */
// sample tick source: internal divider or synchronised external clocks
module wsq_sample_clock
  import wsq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // source choice and divider
  input wire logic [1:0] clk_src,
  input wire logic [DIV_W-1:0] int_div,
  // external clock pins
  input wire logic sclk_ext_pin,
  input wire logic ecl_trg0_pin,
  // one-cycle sample tick
  output logic tick
);
  logic [2:0] ext_sync_reg;  // synchroniser plus edge stage
  logic [2:0] ecl_sync_reg;  // synchroniser plus edge stage
  logic [DIV_W-1:0] div_cnt_reg;  // internal divider count
  logic tick_reg;
  wire use_int = (clk_src == SRC_INT);
  wire ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  wire ecl_rise = ecl_sync_reg[1] && !ecl_sync_reg[2];
  wire int_tick = use_int && (div_cnt_reg >= int_div);
  // only the selected source is heard; others are ignored
  wire tick_next = int_tick || (clk_src == SRC_EXT && ext_rise) ||
                   (clk_src == SRC_ECL && ecl_rise);
  assign tick = tick_reg;

  // synchronisers for the clock pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_sync_reg <= '0;
      ecl_sync_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], sclk_ext_pin};
      ecl_sync_reg <= {ecl_sync_reg[1:0], ecl_trg0_pin};
    end
  end

  // divider held idle while an external source paces points
  always_ff @(posedge clk) begin
    if (!rst_n || !use_int || int_tick) div_cnt_reg <= '0;
    else div_cnt_reg <= div_cnt_reg + 1'b1;
  end

  // registered tick
  always_ff @(posedge clk) begin
    if (!rst_n) tick_reg <= 1'b0;
    else tick_reg <= tick_next;
  end
endmodule

/* wsq_sequencer.sv */
// link table sequencer with sample clock pacing and output fifo
module wsq_sequencer
  import wsq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample clock setup
  input wire logic [1:0] clk_src,
  input wire logic [DIV_W-1:0] int_div,
  input wire logic sclk_ext_pin,
  input wire logic ecl_trg0_pin,
  // rate and format setup
  input wire logic rate_set,
  input wire logic [RATE_W-1:0] rate_val,
  input wire logic legacy_fmt,
  output logic [RATE_W-1:0] rate_cur,
  // table editing
  input wire logic [TAB_W-1:0] edit_tab,
  input wire logic link_wr,
  input wire logic [LINK_W-1:0] link_no,
  input wire wsq_link_type link_in,
  input wire logic link_del,
  input wire logic tab_clear,
  // table choice and sequenced mode
  input wire logic act_set,
  input wire logic [TAB_W-1:0] act_idx,
  input wire logic seq_en,
  // run and advance modes
  input wire logic [1:0] run_mode,
  input wire logic adv_set,
  input wire logic [1:0] adv_in,
  output logic [1:0] adv_mode,
  // trigger and gate pins
  input wire logic trig_pin,
  input wire logic gate_pin,
  // segment length lookup
  output logic [SEG_W-1:0] seg_query,
  input wire logic [PT_W-1:0] seg_points,
  // sync output
  input wire logic sync_bit_mode,
  output logic sync_out,
  // point stream
  output logic out_valid,
  input wire logic out_ready,
  output wsq_word_type out_word,
  // status
  output logic running,
  output logic holding,
  output logic [TAB_W-1:0] act_tab,
  output logic [LINK_W-1:0] cur_link,
  output wsq_err_type err,
  input wire logic err_clear
);
  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PLAY = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } wsq_state_type;

  wsq_state_type state_reg, state_next;  // sequencer state
  wsq_link_type tbl_reg [N_TABLES][N_LINKS];  // link tables
  wsq_link_type ent_next [N_TABLES][N_LINKS];  // table next values
  logic [LEN_W-1:0] len_reg [N_TABLES];  // links per table
  logic [LEN_W-1:0] len_next [N_TABLES];
  logic [TAB_W-1:0] act_reg;  // active table
  logic [1:0] adv_reg;  // advance mode
  logic [RATE_W-1:0] rate_reg;  // accepted sample rate
  logic [LINK_W-1:0] link_reg, link_next;  // current link
  logic [PT_W-1:0] pt_reg, pt_next;  // current point
  logic [LOOP_W-1:0] loop_reg, loop_next;  // loops left
  logic [2:0] trig_sync_reg;  // trigger synchroniser plus edge stage
  logic [1:0] gate_sync_reg;  // gate synchroniser
  logic trig_pend_reg;  // trigger seen, not yet used
  logic sequence_span_marker_reg;  // span level of sync
  logic sync_pulse_reg;  // per-link sync pulse
  logic hold_reg;  // output holding last level
  wsq_word_type word_reg;  // last word offered
  wsq_err_type err_reg;  // sticky errors
  wire tick;  // sample clock tick
  wire fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // sample clock and input synchronisers
  wsq_sample_clock u_sclk (
    .clk(clk),
    .rst_n(rst_n),
    .clk_src(clk_src),
    .int_div(int_div),
    .sclk_ext_pin(sclk_ext_pin),
    .ecl_trg0_pin(ecl_trg0_pin),
    .tick(tick)
  );

  // trigger and gate pins pass two flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_sync_reg <= '0;
      gate_sync_reg <= '0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], trig_pin};
      gate_sync_reg <= {gate_sync_reg[0], gate_pin};
    end
  end
  wire trig_evt = trig_sync_reg[1] && !trig_sync_reg[2];
  wire gate_on = gate_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // command checks
  wire [LEN_W-1:0] edit_len = len_reg[edit_tab];
  wire tab_ok = (edit_tab < TAB_W'(N_TABLES));
  wire seg_ok = (link_in.seg >= SEG_MIN) && (link_in.seg <= SEG_MAX);
  wire loop_ok = (link_in.loops >= LOOP_MIN) && (link_in.loops <= LOOP_MAX);
  wire wr_ok = link_wr && tab_ok && seg_ok && loop_ok &&
               ({1'b0, link_no} <= edit_len) && (edit_len != LEN_W'(N_LINKS));
  wire del_ok = link_del && tab_ok && ({1'b0, link_no} < edit_len);
  wire clr_ok = tab_clear && tab_ok;
  wire act_ok = act_set && (act_idx < TAB_W'(N_TABLES));
  wire cmd_bad = (link_wr && !wr_ok) || (link_del && !del_ok) ||
                 (tab_clear && !clr_ok) || (act_set && !act_ok);
  // triggered advance needs triggered run; step and mix need continuous
  wire adv_conflict = adv_set &&
    (((adv_in == ADV_TRIG) && (run_mode != RUN_TRIG)) ||
     ((adv_in == ADV_STEP || adv_in == ADV_MIX) && (run_mode != RUN_CONT)));
  wire [RATE_W-1:0] rate_top = legacy_fmt ? RATE_MAX_LEGACY : RATE_MAX;
  wire rate_ok = (rate_val >= RATE_MIN) && (rate_val <= rate_top);

  ////////////////////////////////////////////////////////////////////////////
  // table next values: write, delete by shifting down, clear
  for (genvar t = 0; t < N_TABLES; t++) begin : g_tab
    wire sel_t = (edit_tab == TAB_W'(t));
    for (genvar i = 0; i < N_LINKS; i++) begin : g_link
      wire wr_hit = wr_ok && sel_t && (link_no == LINK_W'(i));
      wire shift_hit = del_ok && sel_t && (LINK_W'(i) >= link_no) && (i < N_LINKS - 1);
      assign ent_next[t][i] = wr_hit ? link_in :
                              shift_hit ? tbl_reg[t][(i + 1) % N_LINKS] : tbl_reg[t][i];
    end
    assign len_next[t] = (clr_ok && sel_t) ? '0 :
                         (del_ok && sel_t) ? len_reg[t] - 1'b1 :
                         (wr_ok && sel_t && {1'b0, link_no} == len_reg[t]) ?
                         len_reg[t] + 1'b1 : len_reg[t];
  end

  // table storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_reg <= '{default: '0};
      len_reg <= '{default: '0};
    end else begin
      tbl_reg <= ent_next;
      len_reg <= len_next;
    end
  end

  // setup registers; choosing a table leaves sequenced mode alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_reg <= '0;
      adv_reg <= ADV_AUTO;
      rate_reg <= RATE_MIN;
    end else begin
      if (act_ok) act_reg <= act_idx;
      if (adv_set && !adv_conflict) adv_reg <= adv_in;
      if (rate_set && rate_ok) rate_reg <= rate_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer decode
  wire [LEN_W-1:0] act_len = len_reg[act_reg];
  wsq_link_type cur_ent;
  wsq_link_type first_ent;
  wsq_link_type nxt_ent;
  assign cur_ent = tbl_reg[act_reg][link_reg];
  assign first_ent = tbl_reg[act_reg][0];
  wire last_link = ({1'b0, link_reg} + 1'b1) >= act_len;
  wire [LINK_W-1:0] nxt_link = last_link ? '0 : link_reg + 1'b1;
  assign nxt_ent = tbl_reg[act_reg][nxt_link];
  wire have_seq = seq_en && (act_len != '0);
  wire emit = (state_reg == ST_PLAY) && tick && fifo_in_ready;
  wire seg_end = (pt_reg >= seg_points - 1'b1);
  // step mode and mixed flag 1 repeat until a trigger arrives
  wire hold_link = (adv_reg == ADV_STEP) || (adv_reg == ADV_MIX && cur_ent.adv);
  wire loops_done = (loop_reg <= LOOP_MIN);
  wire first_pt = (pt_reg == '0) && (loop_reg == cur_ent.loops);
  wire start_ok = (run_mode == RUN_CONT) || (run_mode == RUN_TRIG && trig_pend_reg) ||
                  (run_mode == RUN_GATE && gate_on);
  // at the end of the last link: wrap, or stop holding the level
  wire wrap_ok = (run_mode == RUN_CONT) || (run_mode == RUN_GATE && gate_on);
  wire link_end = emit && seg_end && (hold_link ? trig_pend_reg : loops_done);
  wire trig_take;
  wire [PT_W-1:0] len_mask = legacy_fmt ? LEN_MASK_LEGACY : LEN_MASK_NORMAL;
  wire len_bad = emit && (pt_reg == '0) &&
                 (((seg_points & len_mask) != '0) || (seg_points == '0));

  // next state, link, point and loop count
  always_comb begin
    state_next = state_reg;
    link_next = link_reg;
    pt_next = pt_reg;
    loop_next = loop_reg;
    if (!have_seq) begin
      state_next = ST_IDLE;
      link_next = '0;
      pt_next = '0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (start_ok) begin
            state_next = ST_PLAY;
            link_next = '0;
            pt_next = '0;
            loop_next = first_ent.loops;
          end
        end
        ST_PLAY: begin
          if (emit) begin
            if (!seg_end) begin
              pt_next = pt_reg + 1'b1;
            end else if (!link_end) begin
              pt_next = '0;
              if (!hold_link) loop_next = loop_reg - 1'b1;
            end else if (adv_reg == ADV_TRIG) begin
              state_next = last_link ? ST_DONE : ST_WAIT;
            end else if (last_link && !wrap_ok) begin
              state_next = ST_DONE;
            end else begin
              link_next = nxt_link;
              pt_next = '0;
              loop_next = nxt_ent.loops;
            end
          end
        end
        ST_WAIT: begin
          if (trig_pend_reg) begin
            state_next = ST_PLAY;
            link_next = nxt_link;
            pt_next = '0;
            loop_next = nxt_ent.loops;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // a trigger is used when it starts, releases or steps a link
  assign trig_take = have_seq &&
    (((state_reg == ST_IDLE || state_reg == ST_DONE) && run_mode == RUN_TRIG) ||
     (state_reg == ST_WAIT) || (link_end && hold_link));

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      link_reg <= '0;
      pt_reg <= '0;
      loop_reg <= LOOP_MIN;
    end else begin
      state_reg <= state_next;
      link_reg <= link_next;
      pt_reg <= pt_next;
      loop_reg <= loop_next;
    end
  end

  // pending trigger; a new edge wins over a take in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) trig_pend_reg <= 1'b0;
    else trig_pend_reg <= trig_evt || (trig_pend_reg && !trig_take);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync output and hold flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sequence_span_marker_reg <= 1'b0;
      sync_pulse_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      // span: high from first point of link zero to the end of the last link
      if (!have_seq) sequence_span_marker_reg <= 1'b0;
      else if (emit && link_reg == '0 && first_pt) sequence_span_marker_reg <= 1'b1;
      else if (link_end && last_link) sequence_span_marker_reg <= 1'b0;
      // bit source: one sample wide on links whose sync flag is set
      if (emit) sync_pulse_reg <= cur_ent.sync && first_pt;
      else if (tick) sync_pulse_reg <= 1'b0;
      hold_reg <= (state_next == ST_WAIT) || (state_next == ST_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stream word and fifo
  always_ff @(posedge clk) begin
    if (!rst_n) word_reg <= '0;
    else if (emit) word_reg <= '{seg: cur_ent.seg, point: pt_reg, sync: cur_ent.sync};
  end

  logic emit_d_reg;  // word_reg holds a fresh word
  always_ff @(posedge clk) begin
    if (!rst_n) emit_d_reg <= 1'b0;
    else emit_d_reg <= emit;
  end

  wire fifo_space;
  // no point is emitted while a word is in flight, so none is dropped
  assign fifo_in_ready = fifo_space && !emit_d_reg;
  wsq_fifo #(
    .WIDTH($bits(wsq_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(emit_d_reg),
    .in_ready(fifo_space),
    .in_data(word_reg),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky errors; a new error wins over a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_reg <= '0;
    end else begin
      err_reg.rate <= (rate_set && !rate_ok) || (err_reg.rate && !err_clear);
      err_reg.len <= len_bad || (err_reg.len && !err_clear);
      err_reg.conflict <= adv_conflict || (err_reg.conflict && !err_clear);
      err_reg.cmd <= cmd_bad || (err_reg.cmd && !err_clear);
    end
  end

  // status outputs
  assign rate_cur = rate_reg;
  assign adv_mode = adv_reg;
  assign act_tab = act_reg;
  assign cur_link = link_reg;
  assign seg_query = cur_ent.seg;
  assign sync_out = sync_bit_mode ? sync_pulse_reg : sequence_span_marker_reg;
  assign running = (state_reg == ST_PLAY);
  assign holding = hold_reg;
  assign err = err_reg;
endmodule

/* wsq_chk.sv */
// port-level checks of the waveform sequencer
module wsq_chk
  import wsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rate_set,
  input wire logic [RATE_W-1:0] rate_val,
  input wire logic legacy_fmt,
  input wire logic [RATE_W-1:0] rate_cur,
  input wire logic adv_set,
  input wire logic [1:0] adv_in,
  input wire logic [1:0] run_mode,
  input wire logic [1:0] adv_mode,
  input wire logic act_set,
  input wire logic [TAB_W-1:0] act_idx,
  input wire logic [TAB_W-1:0] act_tab,
  input wire logic seq_en,
  input wire logic running,
  input wire logic holding,
  input wire logic [SEG_W-1:0] seg_query,
  input wire wsq_err_type err,
  input wire logic err_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request shapes
  sequence s_rate_low;
    rate_set && !err_clear && rate_val < RATE_MIN;
  endsequence
  sequence s_trig_bad;
    adv_set && !err_clear && adv_in == ADV_TRIG && run_mode != RUN_TRIG;
  endsequence
  sequence s_act_idle;
    !seq_en [*2] ##0 (act_set && !running);
  endsequence
  chk_rate_low: assert property (s_rate_low |=> err.rate && $stable(rate_cur))
    else $error("low rate taken");
  chk_rate_take: assert property (rate_set && !legacy_fmt && rate_val >= RATE_MIN
    && rate_val <= RATE_MAX |=> rate_cur == $past(rate_val)) else $error("rate not taken");
  chk_legacy_cap: assert property (rate_set && legacy_fmt && !err_clear
    && rate_val > RATE_MAX_LEGACY |=> err.rate && $stable(rate_cur)) else $error("cap missed");
  chk_trig_conflict: assert property (s_trig_bad |=> err.conflict && $stable(adv_mode))
    else $error("trig advance taken");
  chk_step_conflict: assert property (adv_set && !err_clear && adv_in == ADV_STEP
    && run_mode != RUN_CONT |=> err.conflict) else $error("step advance taken");
  chk_mix_take: assert property (adv_set && adv_in == ADV_MIX && run_mode == RUN_CONT
    |=> adv_mode == ADV_MIX) else $error("mix advance refused");
  chk_act_take: assert property (act_set && act_idx < N_TABLES
    |=> act_tab == $past(act_idx)) else $error("table choice lost");
  chk_act_quiet: assert property (s_act_idle |=> !running)
    else $error("table choice started output");
  chk_seg_range: assert property (running |-> seg_query >= SEG_MIN && seg_query <= SEG_MAX)
    else $error("segment out of range");
  chk_hold_stop: assert property ($rose(holding) |-> !running)
    else $error("holding while playing");
endmodule

/* wsq_partner.sv */
// far side model: segment lengths, stalling sink, trigger and backplane clock
module wsq_partner
  import wsq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // segment length lookup
  input wire logic [SEG_W-1:0] seg_query,
  output logic [PT_W-1:0] seg_points,
  // sink and trigger
  output logic out_ready,
  input wire logic fire,
  output logic trig_pin,
  output logic ecl_trg0_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold, ph;
  // segments are loaded before any table runs; segment 3 is legal in legacy only
  assign seg_points = (seg_query == 15'h0001) ? 24'h00_0004 :
                      (seg_query == 15'h0003) ? 24'h00_0006 : 24'h00_0008;
  initial begin
    out_ready = 0;
    trig_pin = 0;
    hold = 0;
    ph = 0;
    ecl_trg0_pin = 0;
  end
  // random sink stalls; trigger stretched past the pin synchroniser
  always @(posedge clk) begin
    out_ready <= #1 ($urandom_range(3) != 0);
    hold <= #1 fire ? 4 : (hold > 0 ? hold - 1 : 0);
    trig_pin <= #1 (hold > 0);
    // backplane clock at a quarter of clk, far under its bus limit
    ph <= #1 ph + 1;
    ecl_trg0_pin <= #1 ph[1];
  end
endmodule

/* wsq_sequencer_bench.sv */
// self-checking bench of the waveform sequencer
module wsq_sequencer_bench
  import wsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rate_set, legacy_fmt, link_wr, link_del, tab_clear, act_set, seq_en;
  logic adv_set, trig_pin, gate_pin, sclk_ext_pin, ecl_trg0_pin, sync_bit_mode, out_ready;
  logic err_clear, fire, strict, sync_out, out_valid, running, holding;
  logic [1:0] clk_src, run_mode, adv_in, adv_mode;
  logic [DIV_W-1:0] int_div;
  logic [RATE_W-1:0] rate_val, rate_cur, r;
  logic [TAB_W-1:0] edit_tab, act_idx, act_tab;
  logic [LINK_W-1:0] link_no, cur_link;
  logic [SEG_W-1:0] seg_query;
  logic [PT_W-1:0] seg_points;
  wsq_link_type link_in;
  wsq_word_type out_word;
  wsq_err_type err;
  logic [63:0] exp_q[$];
  int n_errors, total_checks, cyc;
  wsq_sequencer wsq_sequencer_i (.clk, .rst_n, .clk_src, .int_div, .sclk_ext_pin,
    .ecl_trg0_pin, .rate_set, .rate_val, .legacy_fmt, .rate_cur, .edit_tab, .link_wr,
    .link_no, .link_in, .link_del, .tab_clear, .act_set, .act_idx, .seq_en, .run_mode,
    .adv_set, .adv_in, .adv_mode, .trig_pin, .gate_pin, .seg_query, .seg_points,
    .sync_bit_mode, .sync_out, .out_valid, .out_ready, .out_word, .running, .holding,
    .act_tab, .cur_link, .err, .err_clear);
  wsq_partner wsq_partner_i (.clk, .rst_n, .seg_query, .seg_points, .out_ready, .fire,
    .trig_pin, .ecl_trg0_pin);
  assign sclk_ext_pin = ecl_trg0_pin;
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step();
    s = 0;
    step();
  endtask
  task automatic set_rate(input logic [RATE_W-1:0] v);
    rate_val = v;
    pulse(rate_set);
  endtask
  task automatic set_adv(input logic [1:0] v);
    adv_in = v;
    pulse(adv_set);
  endtask
  task automatic wr_link(input int no, sg, lp);
    link_no = no[LINK_W-1:0];
    link_in = '{sg[SEG_W-1:0], lp[LOOP_W-1:0], 1'b0, 1'b1};
    pulse(link_wr);
  endtask
  task automatic expect_seg(input int sg, len, reps);
    repeat (reps) for (int p = 0; p < len; p++)
      exp_q.push_back({sg[SEG_W-1:0], p[PT_W-1:0], 1'b1});
  endtask
  task automatic drain();
    for (int i = 0; i < 4000 && exp_q.size() > 0; i++) step();
    check(exp_q.size(), 0);
  endtask
  // stream monitor: oldest note against each word taken
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      close_out();
    end else if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() > 0) check(out_word, exp_q.pop_front());
      else if (strict) check(1, 0);
    end
  end
  initial begin
    r = $urandom(18);
    {rst_n, rate_set, legacy_fmt, link_wr, link_del, tab_clear, act_set, seq_en} = '0;
    {adv_set, gate_pin, sync_bit_mode, err_clear, fire} = '0;
    {strict, clk_src, run_mode, adv_in, edit_tab, act_idx, link_no, rate_val, link_in} = '0;
    int_div = 16'h0003;
    step(6);
    rst_n = 1;
    step();
    check(rate_cur, 40'h00_0000_0064);
    check(adv_mode, ADV_AUTO);
    r = RATE_MIN + $urandom_range(5000);
    set_rate(r);
    check(rate_cur, r);
    set_rate(RATE_MIN - 1);
    check({err.rate, rate_cur}, {1'b1, r});
    legacy_fmt = 1;
    set_rate(RATE_MAX);
    check(rate_cur, r);
    legacy_fmt = 0;
    $display("rate test done");
    set_adv(ADV_TRIG);
    check({err.conflict, adv_mode}, {1'b1, ADV_AUTO});
    set_adv(ADV_MIX);
    check(adv_mode, ADV_MIX);
    run_mode = RUN_TRIG;
    set_adv(ADV_STEP);
    check(adv_mode, ADV_MIX);
    run_mode = RUN_CONT;
    set_adv(ADV_AUTO);
    pulse(err_clear);
    $display("advance test done");
    wr_link(0, 1, 2);
    wr_link(1, 2, 1);
    wr_link(2, 0, 1);
    check(err.cmd, 1'b1);
    pulse(err_clear);
    wr_link(2, 1, 0);
    check(err.cmd, 1'b1);
    pulse(err_clear);
    act_idx = 4'ha;
    pulse(act_set);
    check(act_tab, 4'h0);
    pulse(err_clear);
    act_idx = 4'h0;
    pulse(act_set);
    check(running, 1'b0);
    $display("table test done");
    repeat (2) begin
      expect_seg(1, 4, 2);
      expect_seg(2, 8, 1);
    end
    {clk_src, seq_en} = {SRC_EXT, 1'b1};
    step(12);
    check(sync_out, 1'b1);
    step(36);
    check(cur_link, 4'h1);
    drain();
    seq_en = 0;
    step(60);
    check(err, 4'h0);
    $display("auto test done");
    edit_tab = 4'h1;
    wr_link(0, 2, 3);
    act_idx = 4'h1;
    pulse(act_set);
    run_mode = RUN_TRIG;
    set_adv(ADV_TRIG);
    check(adv_mode, ADV_TRIG);
    expect_seg(2, 8, 3);
    clk_src = SRC_ECL;
    {strict, sync_bit_mode, seq_en} = 3'h7;
    step(20);
    check(running, 1'b0);
    pulse(fire);
    drain();
    step(40);
    check(holding, 1'b1);
    {strict, seq_en} = 2'h0;
    $display("burst test done");
    wr_link(0, 3, 1);
    {legacy_fmt, seq_en} = 2'h3;
    pulse(fire);
    step(40);
    check(err.len, 1'b0);
    legacy_fmt = 0;
    pulse(fire);
    step(40);
    check(err.len, 1'b1);
    seq_en = 0;
    pulse(err_clear);
    $display("length test done");
    link_no = '0;
    pulse(link_del);
    edit_tab = '0;
    pulse(tab_clear);
    run_mode = RUN_CONT;
    set_adv(ADV_AUTO);
    check(err, 4'h0);
    seq_en = 1;
    step(30);
    check(running, 1'b0);
    act_idx = '0;
    pulse(act_set);
    check(running, 1'b0);
    seq_en = 0;
    $display("clear test done");
    close_out();
  end
endmodule
bind wsq_sequencer wsq_chk wsq_chk_i (.clk, .rst_n, .rate_set, .rate_val, .legacy_fmt,
  .rate_cur, .adv_set, .adv_in, .run_mode, .adv_mode, .act_set, .act_idx, .act_tab, .seq_en,
  .running, .holding, .seg_query, .err, .err_clear);
